/* File: cku_pkg.sv */
// Constants and register map of the customer key unlock block
// Functional notes
// - Eight write-only key word registers, index 0 to 7, 32 bits each.
// - Unlock compares the full 256-bit assembled key with the stored reference key.
// - Reference key loads only from the flash security-setting write, never from registers.
// - Word index k supplies key bits 32k+31 down to 32k.
// - A match releases customer key protection over code flash and settings.
// - The result shows in a read-only bit of the key check status register.
package cku_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int KEY_WORDS = 8;
   localparam int KEY_W = 256;
   localparam int IDX_W = 3;

   // Byte offsets of the register map
   localparam logic [7:0] OFF_KEY_WORD_0 = 8'h00;
   localparam logic [7:0] OFF_KEY_WORD_7 = 8'h1C;
   localparam logic [7:0] OFF_KEY_CHECK_STATUS = 8'h20;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

   // Field positions
   localparam int RESULT_FLAG_BIT = 4;
   localparam int EV_MATCH_BIT = 0;
   localparam int EV_MISMATCH_BIT = 1;
   localparam int EV_ORDER_BIT = 2;
   localparam int EV_W = 3;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0] RST_EV = 3'h0;
   localparam logic RST_RESULT_FLAG = 1'b1;
   localparam logic [2:0] LAST_IDX = 3'h7;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      CKU_COLLECT = 2'b01,
      CKU_CHECK = 2'b10
   } cku_state_e;
endpackage

/* File: cku_top.sv */
// Customer key input registers, sequence check and unlock comparison
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module cku_top (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register port
   input wire logic [cku_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [cku_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [cku_pkg::DATA_W-1:0] reg_rdata,
   // Reference key from the security-setting write command
   input wire logic sec_key_load,
   input wire logic [cku_pkg::KEY_W-1:0] sec_key_data,
   // Protection and interrupt
   output logic cust_protect,
   output logic irq
);

   // Word index of a key register address
   function automatic logic [cku_pkg::IDX_W-1:0] key_index(
      input logic [cku_pkg::ADDR_W-1:0] a
   );
      logic [cku_pkg::ADDR_W-1:0] rel;
      rel = a - cku_pkg::OFF_KEY_WORD_0;
      key_index = rel[cku_pkg::IDX_W+1:2];
   endfunction

   // Address falls on an aligned key word
   function automatic logic is_key_addr(
      input logic [cku_pkg::ADDR_W-1:0] a
   );
      // Unaligned addresses inside the key range are ignored, not rounded down
      is_key_addr = (a >= cku_pkg::OFF_KEY_WORD_0)
         && (a <= cku_pkg::OFF_KEY_WORD_7)
         && (a[1:0] == 2'b00);
   endfunction

   // Full-width key equality
   function automatic logic key_match(
      input logic [cku_pkg::KEY_W-1:0] a,
      input logic [cku_pkg::KEY_W-1:0] b
   );
      key_match = (a == b);
   endfunction

   // Stored offered key words
   logic [cku_pkg::DATA_W-1:0] key_q [cku_pkg::KEY_WORDS];
   // Reference key and its validity
   logic [cku_pkg::KEY_W-1:0] ref_key_q;
   logic ref_valid_q;
   // Sequencer
   cku_pkg::cku_state_e state_q;
   logic [cku_pkg::IDX_W-1:0] next_idx_q;
   logic order_ok_q;
   // Result and interrupt state
   logic result_flag_q;
   logic [cku_pkg::EV_W-1:0] ev_sts_q;
   logic [cku_pkg::EV_W-1:0] ev_mask_q;
   logic [cku_pkg::EV_W-1:0] ev_set;
   logic [cku_pkg::EV_W-1:0] ev_clr;
   logic [cku_pkg::DATA_W-1:0] rdata_q;
   logic irq_q;
   logic prot_q;

   // Decoded strobes
   logic key_wr;
   logic [cku_pkg::IDX_W-1:0] wr_idx;
   logic in_order;
   logic go_check;
   logic [cku_pkg::KEY_W-1:0] offered_key;
   logic hit;
   logic seq_restart;

   // Register selects and read mux
   logic sel_status;
   logic sel_irq_sts;
   logic sel_irq_mask;
   logic [cku_pkg::DATA_W-1:0] rd_mux;

   // Register select decode, one select per target
   always_comb begin
      sel_status = 1'b0;
      sel_irq_sts = 1'b0;
      sel_irq_mask = 1'b0;
      if (reg_addr == cku_pkg::OFF_KEY_CHECK_STATUS) begin
         sel_status = 1'b1;
      end else if (reg_addr == cku_pkg::OFF_IRQ_STATUS) begin
         sel_irq_sts = 1'b1;
      end else if (reg_addr == cku_pkg::OFF_IRQ_MASK) begin
         sel_irq_mask = 1'b1;
      end
   end

   // Key writes land only while collecting
   assign key_wr = reg_wr && is_key_addr(reg_addr) && (state_q == cku_pkg::CKU_COLLECT);
   assign wr_idx = key_index(reg_addr);
   assign in_order = order_ok_q && (wr_idx == next_idx_q);
   // Index 0 opens a fresh sequence whatever came before, unless a reference load lands in the same cycle
   assign seq_restart = key_wr && (wr_idx == '0);
   // A same-cycle reference load wins, so a stale key is never compared
   assign go_check = key_wr
      && in_order
      && (wr_idx == cku_pkg::LAST_IDX)
      && !sec_key_load;

   // Assemble the offered key, lowest word in the lowest bits
   always_comb begin
      offered_key = '0;
      offered_key[0*cku_pkg::DATA_W +: cku_pkg::DATA_W] = key_q[0];
      offered_key[1*cku_pkg::DATA_W +: cku_pkg::DATA_W] = key_q[1];
      offered_key[2*cku_pkg::DATA_W +: cku_pkg::DATA_W] = key_q[2];
      offered_key[3*cku_pkg::DATA_W +: cku_pkg::DATA_W] = key_q[3];
      offered_key[4*cku_pkg::DATA_W +: cku_pkg::DATA_W] = key_q[4];
      offered_key[5*cku_pkg::DATA_W +: cku_pkg::DATA_W] = key_q[5];
      offered_key[6*cku_pkg::DATA_W +: cku_pkg::DATA_W] = key_q[6];
      offered_key[7*cku_pkg::DATA_W +: cku_pkg::DATA_W] = key_q[7];
   end

   // Match only against a reference actually loaded
   assign hit = ref_valid_q && key_match(offered_key, ref_key_q);

   // Key word storage, one word per index
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         for (int k = 0; k < cku_pkg::KEY_WORDS; k++) begin
            key_q[k] <= cku_pkg::RST_WORD;
         end
      end else if (key_wr) begin
         key_q[wr_idx] <= reg_wdata;
      end
   end

   // Reference key loads only from the flash command path
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ref_key_q <= '0;
         ref_valid_q <= 1'b0;
      end else if (sec_key_load) begin
         ref_key_q <= sec_key_data;
         ref_valid_q <= 1'b1;
      end
   end

   // Order tracking: index 0 restarts a sequence unless a reference load lands in the same cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         next_idx_q <= '0;
         order_ok_q <= 1'b0;
      end else if (sec_key_load) begin
         // New reference key voids a half-written sequence
         next_idx_q <= '0;
         order_ok_q <= 1'b0;
      end else if (key_wr) begin
         if (seq_restart) begin
            next_idx_q <= 3'h1;
            order_ok_q <= 1'b1;
         end else if (in_order && (wr_idx != cku_pkg::LAST_IDX)) begin
            next_idx_q <= next_idx_q + 3'h1;
         end else begin
            // Last word or a misordered one ends the sequence
            next_idx_q <= '0;
            order_ok_q <= 1'b0;
         end
      end
   end

   // Sequencer: one cycle of compare after the eighth word
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= cku_pkg::CKU_COLLECT;
      end else begin
         case (state_q)
            cku_pkg::CKU_COLLECT: begin
               if (go_check) begin
                  state_q <= cku_pkg::CKU_CHECK;
               end
            end
            cku_pkg::CKU_CHECK: begin
               state_q <= cku_pkg::CKU_COLLECT;
            end
            default: begin
               state_q <= cku_pkg::CKU_COLLECT;
            end
         endcase
      end
   end

   // Result flag: 1 locked, 0 released
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         result_flag_q <= cku_pkg::RST_RESULT_FLAG;
      end else if (sec_key_load) begin
         // Blank or erased reference needs no unlock
         result_flag_q <= !((&sec_key_data) || (sec_key_data == '0));
      end else if ((state_q == cku_pkg::CKU_CHECK) && hit) begin
         result_flag_q <= 1'b0;
      end
   end

   // Protection output follows the result flag
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prot_q <= cku_pkg::RST_RESULT_FLAG;
      end else begin
         prot_q <= result_flag_q;
      end
   end

   // Events raised by the sequencer
   always_comb begin
      ev_set = cku_pkg::RST_EV;
      ev_set[cku_pkg::EV_MATCH_BIT] = (state_q == cku_pkg::CKU_CHECK) && hit;
      ev_set[cku_pkg::EV_MISMATCH_BIT] = (state_q == cku_pkg::CKU_CHECK) && !hit;
      ev_set[cku_pkg::EV_ORDER_BIT] = key_wr && !seq_restart && !in_order;
   end

   // Write-one-to-clear strobes
   assign ev_clr = (reg_wr && sel_irq_sts)
      ? reg_wdata[cku_pkg::EV_W-1:0]
      : cku_pkg::RST_EV;

   // Sticky status; a set in the clearing cycle survives
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ev_sts_q <= cku_pkg::RST_EV;
      end else begin
         ev_sts_q <= (ev_sts_q & ~ev_clr) | ev_set;
      end
   end

   // Interrupt mask
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ev_mask_q <= cku_pkg::RST_EV;
      end else if (reg_wr && sel_irq_mask) begin
         ev_mask_q <= reg_wdata[cku_pkg::EV_W-1:0];
      end
   end

   // Level interrupt, registered so the pin is glitch free
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ev_sts_q & ev_mask_q);
      end
   end

   // Read mux; key words and holes read as zero so the key never leaks
   always_comb begin
      rd_mux = cku_pkg::RST_WORD;
      if (sel_status) begin
         rd_mux[cku_pkg::RESULT_FLAG_BIT] = result_flag_q;
      end else if (sel_irq_sts) begin
         rd_mux[cku_pkg::EV_W-1:0] = ev_sts_q;
      end else if (sel_irq_mask) begin
         rd_mux[cku_pkg::EV_W-1:0] = ev_mask_q;
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= cku_pkg::RST_WORD;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end else begin
         // Data stands only in the cycle after the read
         rdata_q <= cku_pkg::RST_WORD;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = rdata_q;
   assign cust_protect = prot_q;
   assign irq = irq_q;

endmodule

/* File: cku_properties.sv */
// Port checker of the customer key unlock block
`timescale 1ns/10ps
module cku_props (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register port
   input wire logic [cku_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [cku_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [cku_pkg::DATA_W-1:0] reg_rdata,
   // Reference key and outputs
   input wire logic sec_key_load,
   input wire logic [cku_pkg::KEY_W-1:0] sec_key_data,
   input wire logic cust_protect,
   input wire logic irq
);
   logic [2:0] since_q;
   // Age of the last load or last-word write; only these may open the lock
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         since_q <= 3'h7;
      end else if (sec_key_load || (reg_wr && reg_addr == cku_pkg::OFF_KEY_WORD_7)) begin
         since_q <= 3'h0;
      end else if (since_q != 3'h7) begin
         since_q <= since_q + 3'h1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_reset_values: assert property ($rose(nrst) |-> cust_protect && !irq && reg_rdata == '0)
      else $error("bad outputs after reset");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside read slot");
   a_key_readzero: assert property ($past(reg_rd) && ($past(reg_addr) < 8'h20 || $past(reg_addr) > 8'h28)
      |-> reg_rdata == '0)
      else $error("key word or hole readable");
   a_status_layout: assert property ($past(reg_rd) && $past(reg_addr) == 8'h20
      |-> reg_rdata[31:5] == '0 && reg_rdata[3:0] == '0)
      else $error("status spare bits set");
   a_flag_match: assert property ($past(reg_rd) && $past(reg_addr) == 8'h20 |-> reg_rdata[4] == cust_protect)
      else $error("flag and protect disagree");
   a_unlock_cause: assert property ($fell(cust_protect) |-> since_q <= 3'h3)
      else $error("protection dropped without cause");
   a_load_lock: assert property (sec_key_load && sec_key_data != '0 && sec_key_data != '1 ##1 !sec_key_load [*3]
      |-> ##1 cust_protect)
      else $error("load did not lock");
   a_load_open: assert property (sec_key_load && (sec_key_data == '0 || sec_key_data == '1) ##1 !sec_key_load [*3]
      |-> ##1 !cust_protect)
      else $error("trivial key kept lock");
   c_unlock: cover property ($fell(cust_protect));
   c_status: cover property ($past(reg_rd) && $past(reg_addr) == 8'h20);
   c_irq: cover property ($rose(irq));
endmodule
bind cku_top cku_props u_props (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sec_key_load(sec_key_load),
   .sec_key_data(sec_key_data), .cust_protect(cust_protect), .irq(irq));

/* File: testbench.sv */
// Self-checking bench of the customer key unlock block
`timescale 1ns/10ps
module testbench;
   typedef struct {logic [255:0] refk; logic [255:0] offer; logic [2:0] ev; logic prot;} cku_row_s;
   logic clock = 0, nrst = 0, reg_wr = 0, reg_rd = 0, sec_key_load = 0, cust_protect, irq;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, d;
   logic [255:0] sec_key_data = '0, k;
   int bad_count = 0, n_compared = 0;
   cku_row_s rows [5];
   // 40 MHz clock
   always #12.5 clock = ~clock;
   cku_top dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sec_key_load(sec_key_load), .sec_key_data(sec_key_data),
      .cust_protect(cust_protect), .irq(irq));
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   // Sample one step after the edge so its updates have landed
   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      tick(1);
      reg_rd <= 1'b0;
      d = reg_rdata;
   endtask
   task load(input logic [255:0] v);
      @(posedge clock);
      sec_key_load <= 1'b1;
      sec_key_data <= v;
      @(posedge clock);
      sec_key_load <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   task key(input logic [255:0] v, input int i);
      wr(8'(4 * i), v[32 * i +: 32]);
   endtask
   task end_sim;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      // Distinct words so a swapped word order cannot match
      for (int i = 0; i < 8; i++) k[32 * i +: 32] = 32'hC0DE_0000 + 32'(i * 257);
      rows[0] = '{k, k, 3'h1, 1'b0};
      rows[1] = '{k, k ^ {1'b1, 255'h0}, 3'h2, 1'b1};
      rows[2] = '{k, k ^ 256'h1, 3'h2, 1'b1};
      rows[3] = '{'0, k, 3'h2, 1'b0};
      rows[4] = '{'1, '1, 3'h1, 1'b0};
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      wr(8'h28, 32'h0000_0007);
      foreach (rows[r]) begin
         load(rows[r].refk);
         for (int i = 0; i < 8; i++) key(rows[r].offer, i);
         tick(4);
         chk(32'(cust_protect), 32'(rows[r].prot));
         chk(32'(irq), 32'(rows[r].ev != 3'h0));
         rd(8'h20);
         chk(d, {27'h0, rows[r].prot, 4'h0});
         rd(8'h24);
         chk(d, {29'h0, rows[r].ev});
         wr(8'h24, 32'h0000_0007);
         tick(2);
         chk(32'(irq), 32'h0);
      end
      // Skipped index with the event masked
      load(k);
      wr(8'h28, 32'h0000_0000);
      key(k, 0);
      key(k, 2);
      tick(3);
      chk(32'(irq), 32'h0);
      rd(8'h24);
      chk(d, 32'h0000_0004);
      wr(8'h28, 32'h0000_0007);
      tick(2);
      chk(32'(irq), 32'h1);
      wr(8'h24, 32'h0000_0007);
      for (int i = 2; i < 8; i++) key(k, i);
      tick(4);
      chk(32'(cust_protect), 32'h1);
      // Index 0 mid-sequence restarts with good words
      for (int i = 0; i < 11; i++) key(i < 3 ? k ^ 256'h1 : k, i < 3 ? i : i - 3);
      tick(4);
      chk(32'(cust_protect), 32'h0);
      wr(8'h20, 32'h0000_0010);
      rd(8'h20);
      chk(d, 32'h0);
      rd(8'h04);
      chk(d, 32'h0);
      rd(8'h3C);
      chk(d, 32'h0);
      // Reset in mid-run relocks; key words never become the reference
      nrst <= 1'b0;
      tick(2);
      chk(32'({cust_protect, irq}), 32'h2);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++) key(k, i);
      tick(4);
      chk(32'(cust_protect), 32'h1);
      end_sim;
   end
endmodule
